// ===== rtl/mcuid_pkg.sv
package mcuid_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned PC_W = 11;
  localparam int unsigned FA_W = 7;
  localparam int unsigned STACK_DEPTH = 8;
  // Instruction classes in bits 13:12
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Field positions
  localparam int unsigned CLS_HI = 13;
  localparam int unsigned CLS_LO = 12;
  localparam int unsigned OP_HI = 11;
  localparam int unsigned OP_LO = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned BIDX_HI = 9;
  localparam int unsigned BIDX_LO = 7;
  localparam int unsigned JMP_SEL = 11;
  // Byte-oriented operation fields
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_ROT_R = 4'hC;
  localparam logic [3:0] OP_ROT_L = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  // Bit-oriented operation fields
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKC = 2'h2;
  localparam logic [1:0] BOP_SKS = 2'h3;
  // Literal operation fields
  localparam logic [1:0] LIT_LOAD_TOP = 2'h0;
  localparam logic [1:0] LIT_RET_TOP = 2'h1;
  localparam logic [3:0] LOP_IOR = 4'h8;
  localparam logic [3:0] LOP_AND = 4'h9;
  localparam logic [3:0] LOP_XOR = 4'hA;
  localparam logic [2:0] LIT_SUB_TOP = 3'h6;
  localparam logic [2:0] LIT_ADD_TOP = 3'h7;
  // Fixed control codes
  localparam logic [13:0] CODE_RETURN = 14'h0008;
  localparam logic [13:0] CODE_IRET = 14'h0009;
  localparam logic [13:0] CODE_SLEEP = 14'h0063;
  localparam logic [13:0] CODE_WDOG = 14'h0064;
  // File addresses with side effects, and program counter steps of one and two
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_ADDR = 7'h05;
  localparam logic [10:0] PC_ONE = 11'h001;
  localparam logic [10:0] PC_TWO = 11'h002;
  // Register port map
  localparam logic [1:0] REG_MIRROR = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] MIRROR_RESET = 8'h00;

  typedef enum logic [3:0] {
    ALU_PASS_A, ALU_PASS_W, ALU_CLR, ALU_ADD, ALU_SUB, ALU_INC, ALU_DEC,
    ALU_IOR, ALU_AND, ALU_XOR, ALU_COM, ALU_ROTL, ALU_ROTR, ALU_SWAP,
    ALU_BCLR, ALU_BSET
  } mcuid_alu_op_t;

  typedef struct packed {
    logic to;
    logic pwrdn;
    logic z;
    logic dc;
    logic c;
  } mcuid_flags_t;

  typedef struct packed {
    mcuid_alu_op_t op;
    logic lit;
    logic wr_w;
    logic wr_f;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic skip_z;
    logic skip_clr;
    logic skip_set;
    logic call;
    logic jump;
    logic ret;
    logic sleep;
    logic wdt;
  } mcuid_dec_t;

  typedef enum logic [4:0] {
    ST_FETCH = 5'h01,
    ST_EXEC = 5'h02,
    ST_NOPF = 5'h04,
    ST_NOPE = 5'h08,
    ST_SLEEP = 5'h10
  } mcuid_state_t;
endpackage

// ===== rtl/mcuid_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mcuid_alu
  import mcuid_pkg::*;
(
  input wire mcuid_pkg::mcuid_alu_op_t op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] w_i,
  input wire logic c_i,
  input wire logic [2:0] bit_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic dc_o
);
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] mask;

  // Shared adder and bit mask
  assign sum9 = {1'b0, a_i} + {1'b0, w_i};
  assign nib5 = {1'b0, a_i[3:0]} + {1'b0, w_i[3:0]};
  assign mask = 8'h01 << bit_i;

  // Result and carry per operation
  always_comb begin
    res_o = a_i;
    c_o = c_i;
    dc_o = 1'b0;
    unique case (op_i)
      ALU_PASS_A: res_o = a_i;
      ALU_PASS_W: res_o = w_i;
      ALU_CLR: res_o = 8'h00;
      ALU_ADD: begin
        res_o = sum9[7:0];
        c_o = sum9[8];
        dc_o = nib5[4];
      end
      ALU_SUB: begin
        res_o = a_i - w_i;
        c_o = (a_i >= w_i);
        dc_o = (a_i[3:0] >= w_i[3:0]);
      end
      ALU_INC: res_o = a_i + 8'h01;
      ALU_DEC: res_o = a_i - 8'h01;
      ALU_IOR: res_o = a_i | w_i;
      ALU_AND: res_o = a_i & w_i;
      ALU_XOR: res_o = a_i ^ w_i;
      ALU_COM: res_o = ~a_i;
      ALU_ROTL: begin
        res_o = {a_i[6:0], c_i};
        c_o = a_i[7];
      end
      ALU_ROTR: begin
        res_o = {c_i, a_i[7:1]};
        c_o = a_i[0];
      end
      ALU_SWAP: res_o = {a_i[3:0], a_i[7:4]};
      ALU_BCLR: res_o = a_i & ~mask;
      ALU_BSET: res_o = a_i | mask;
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/mcuid_stack.sv
`timescale 1ns/1ps
`default_nettype none
module mcuid_stack
  import mcuid_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [10:0] data_i,
  output logic [10:0] top_o
);
  logic [10:0] ent_q [STACK_DEPTH];

  // Shift stack, top held in entry zero
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ent_q[i] <= 11'h000;
      end else if (push_i) begin
        if (i == 0) begin
          ent_q[i] <= data_i;
        end else begin
          ent_q[i] <= ent_q[(i == 0) ? 0 : i - 1];
        end
      end else if (pop_i && (i < STACK_DEPTH - 1)) begin
        ent_q[i] <= ent_q[(i < STACK_DEPTH - 1) ? i + 1 : i];
      end
    end
  end

  assign top_o = ent_q[0];
endmodule
`default_nettype wire

// ===== rtl/mcuid_core.sv
`timescale 1ns/1ps
`default_nettype none
//Contract
//RULE1: Class 00 is byte op, d, address
//RULE2: File OR/AND/XOR set zero only
//RULE3: Rotates through carry touch carry only
//RULE4: Count-and-skip skips on zero, no flags
//RULE5: Class 01 bit ops, no flags
//RULE6: Literal OR/AND/XOR update zero
//RULE7: Literal subtract and add set C DC Z
//RULE8: Load literal; return with literal, two cycles
//RULE9: Return and interrupt return, two cycles
//RULE10: Standby code sets timeout, clears powerdown
//RULE11: Watchdog clear sets timeout and powerdown
//RULE12: Port operand comes from pin levels
//RULE13: Timer zero write clears assigned prescaler
//RULE14: Branch or taken skip adds NOP cycle
//RULE15: Mirror holds comparator outputs, read only
//RULE16: Destination bit picks W or file
//RULE17: Call and jump load eleven-bit target
//RULE18: Add, subtract, clear flag updates
module mcuid_core
  import mcuid_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [13:0] pm_data_i,
  output logic [10:0] pm_addr_o,
  output logic [6:0] file_addr_o,
  input wire logic [7:0] file_rdata_i,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  input wire logic [7:0] port_pins_i,
  input wire logic cmp1_output_i,
  input wire logic cmp2_output_i,
  input wire logic prescaler_on_timer_i,
  output logic prescaler_clear_o,
  output logic wdt_clear_o,
  input wire logic wake_i,
  output logic sleep_o,
  output logic [7:0] w_o,
  output mcuid_pkg::mcuid_flags_t status_o,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  import mcuid_pkg::*;

  mcuid_state_t state_q;
  logic [13:0] instr_q;
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pins_q;
  logic [1:0] cmp_s1_q, cmp_s2_q, cmp_s3_q, cmp_q;
  logic [7:0] ctrl_q;
  mcuid_dec_t dec;
  logic [7:0] a_src, opnd_w, res, bit_sel;
  logic alu_c, alu_dc, two_cyc, skip_take, tmr_hit;
  logic st_exec;
  logic [10:0] stack_top;

  // Hold each bit until second and third stages agree
  function automatic logic [7:0] agree(input logic [7:0] s2, input logic [7:0] s3,
                                       input logic [7:0] q);
    agree = (s2 & s3) | (q & (s2 | s3));
  endfunction

  // Instruction word to control bundle
  function automatic mcuid_dec_t decode(input logic [13:0] ins);
    mcuid_dec_t d;
    d = '0;
    d.op = ALU_PASS_A;
    unique case (ins[CLS_HI:CLS_LO])
      CLS_BYTE: begin
        if (ins == CODE_RETURN || ins == CODE_IRET) begin
          d.ret = 1'b1; // RULE9
        end else if (ins == CODE_SLEEP) begin
          d.sleep = 1'b1; // RULE10
        end else if (ins == CODE_WDOG) begin
          d.wdt = 1'b1; // RULE11
        end else begin
          d.wr_f = ins[DEST_BIT]; // RULE1 RULE16
          d.wr_w = ~ins[DEST_BIT]; // RULE16
          unique case (ins[OP_HI:OP_LO])
            OP_MOVWF: begin
              d.op = ALU_PASS_W;
              d.wr_w = 1'b0;
            end
            OP_CLR: begin
              d.op = ALU_CLR; // RULE18
              d.upd_z = 1'b1;
            end
            OP_SUB: begin
              d.op = ALU_SUB; // RULE18
              d.upd_c = 1'b1;
              d.upd_dc = 1'b1;
              d.upd_z = 1'b1;
            end
            OP_ADD: begin
              d.op = ALU_ADD; // RULE18
              d.upd_c = 1'b1;
              d.upd_dc = 1'b1;
              d.upd_z = 1'b1;
            end
            OP_IOR, OP_AND, OP_XOR: begin
              d.op = (ins[OP_HI:OP_LO] == OP_IOR) ? ALU_IOR :
                     (ins[OP_HI:OP_LO] == OP_AND) ? ALU_AND : ALU_XOR; // RULE2
              d.upd_z = 1'b1;
            end
            OP_DEC, OP_INC, OP_COM, OP_MOVF: begin
              d.op = (ins[OP_HI:OP_LO] == OP_DEC) ? ALU_DEC :
                     (ins[OP_HI:OP_LO] == OP_INC) ? ALU_INC :
                     (ins[OP_HI:OP_LO] == OP_COM) ? ALU_COM : ALU_PASS_A;
              d.upd_z = 1'b1;
            end
            OP_DECSZ, OP_INCSZ: begin
              d.op = (ins[OP_HI:OP_LO] == OP_DECSZ) ? ALU_DEC : ALU_INC; // RULE4
              d.skip_z = 1'b1;
            end
            OP_ROT_L: begin
              d.op = ALU_ROTL; // RULE3
              d.upd_c = 1'b1;
            end
            OP_ROT_R: begin
              d.op = ALU_ROTR; // RULE3
              d.upd_c = 1'b1;
            end
            OP_SWAP: d.op = ALU_SWAP;
          endcase
        end
      end
      CLS_BIT: begin
        unique case (ins[OP_HI:BIDX_HI + 1]) // RULE5
          BOP_CLR: begin
            d.op = ALU_BCLR;
            d.wr_f = 1'b1;
          end
          BOP_SET: begin
            d.op = ALU_BSET;
            d.wr_f = 1'b1;
          end
          BOP_SKC: d.skip_clr = 1'b1;
          BOP_SKS: d.skip_set = 1'b1;
        endcase
      end
      CLS_JUMP: begin
        d.jump = 1'b1; // RULE17
        d.call = ~ins[JMP_SEL];
      end
      CLS_LIT: begin
        d.lit = 1'b1;
        d.wr_w = 1'b1;
        if (ins[OP_HI:OP_HI - 1] == LIT_LOAD_TOP) begin
          d.op = ALU_PASS_A; // RULE8
        end else if (ins[OP_HI:OP_HI - 1] == LIT_RET_TOP) begin
          d.ret = 1'b1; // RULE8
        end else if (ins[OP_HI:OP_HI - 2] == LIT_SUB_TOP ||
                     ins[OP_HI:OP_HI - 2] == LIT_ADD_TOP) begin
          d.op = ins[OP_LO + 1] ? ALU_ADD : ALU_SUB; // RULE7
          d.upd_c = 1'b1;
          d.upd_dc = 1'b1;
          d.upd_z = 1'b1;
        end else if (ins[OP_HI:OP_LO] == LOP_IOR) begin
          d.op = ALU_IOR; // RULE6
          d.upd_z = 1'b1;
        end else if (ins[OP_HI:OP_LO] == LOP_AND) begin
          d.op = ALU_AND; // RULE6
          d.upd_z = 1'b1;
        end else if (ins[OP_HI:OP_LO] == LOP_XOR) begin
          d.op = ALU_XOR; // RULE6
          d.upd_z = 1'b1;
        end else begin
          d.wr_w = 1'b0;
        end
      end
    endcase
    return d;
  endfunction

  // Execute-stage datapath
  always_comb begin
    st_exec = (state_q == ST_EXEC);
    dec = decode(instr_q);
    a_src = (file_addr_o == PORT_ADDR) ? pins_q : file_rdata_i; // RULE12
    if (dec.lit) begin
      a_src = instr_q[7:0];
    end
    opnd_w = w_o;
    bit_sel = a_src >> instr_q[BIDX_HI:BIDX_LO];
    skip_take = (dec.skip_z && (res == 8'h00)) || (dec.skip_clr && !bit_sel[0]) ||
                (dec.skip_set && bit_sel[0]); // RULE4 RULE5
    two_cyc = dec.jump || dec.ret || skip_take; // RULE14
    tmr_hit = dec.wr_f && (file_addr_o == TIMER_ZERO_ADDR) && prescaler_on_timer_i; // RULE13
  end

  mcuid_alu u_alu (
    .op_i(dec.op),
    .a_i(a_src),
    .w_i(opnd_w),
    .c_i(status_o.c),
    .bit_i(instr_q[BIDX_HI:BIDX_LO]),
    .res_o(res),
    .c_o(alu_c),
    .dc_o(alu_dc)
  );

  mcuid_stack u_stack (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .push_i(st_exec && dec.call), // RULE17
    .pop_i(st_exec && dec.ret),
    .data_i(pm_addr_o + PC_ONE),
    .top_o(stack_top)
  );

  // Pin and comparator synchronisers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
      pin_s3_q <= 8'h00;
      pins_q <= 8'h00;
      cmp_s1_q <= 2'h0;
      cmp_s2_q <= 2'h0;
      cmp_s3_q <= 2'h0;
      cmp_q <= 2'h0;
    end else begin
      pin_s1_q <= port_pins_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pins_q <= agree(pin_s2_q, pin_s3_q, pins_q);
      cmp_s1_q <= {cmp2_output_i, cmp1_output_i};
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      cmp_q <= 2'(agree(8'(cmp_s2_q), 8'(cmp_s3_q), 8'(cmp_q))); // RULE15
    end
  end

  // Sequencer: fetch, execute, optional NOP cycle, standby
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_FETCH;
    end else begin
      unique case (state_q)
        ST_FETCH: state_q <= ctrl_q[CTRL_RUN_BIT] ? ST_EXEC : ST_FETCH;
        ST_EXEC: state_q <= dec.sleep ? ST_SLEEP : (two_cyc ? ST_NOPF : ST_FETCH); // RULE14
        ST_NOPF: state_q <= ST_NOPE;
        ST_NOPE: state_q <= ST_FETCH;
        ST_SLEEP: state_q <= wake_i ? ST_FETCH : ST_SLEEP;
      endcase
    end
  end

  // Instruction latch and file address
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_q <= 14'h0000;
      file_addr_o <= 7'h00;
    end else if (state_q == ST_FETCH && ctrl_q[CTRL_RUN_BIT]) begin
      instr_q <= pm_data_i;
      file_addr_o <= pm_data_i[FA_W - 1:0]; // RULE1
    end
  end

  // Program counter
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pm_addr_o <= 11'h000;
    end else if (st_exec) begin
      if (dec.jump) begin
        pm_addr_o <= instr_q[PC_W - 1:0]; // RULE17
      end else if (dec.ret) begin
        pm_addr_o <= stack_top; // RULE8 RULE9
      end else if (skip_take) begin
        pm_addr_o <= pm_addr_o + PC_TWO; // RULE4
      end else begin
        pm_addr_o <= pm_addr_o + PC_ONE;
      end
    end
  end

  // W and file write-back
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w_o <= 8'h00;
      file_we_o <= 1'b0;
      file_wdata_o <= 8'h00;
      prescaler_clear_o <= 1'b0;
    end else begin
      file_we_o <= st_exec && dec.wr_f; // RULE16
      prescaler_clear_o <= st_exec && tmr_hit; // RULE13
      if (st_exec && dec.wr_f) begin
        file_wdata_o <= res;
      end
      if (st_exec && dec.wr_w) begin
        w_o <= res; // RULE16
      end
    end
  end

  // Status flags and power control
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_o <= '{to: 1'b1, pwrdn: 1'b1, z: 1'b0, dc: 1'b0, c: 1'b0};
      sleep_o <= 1'b0;
      wdt_clear_o <= 1'b0;
    end else begin
      wdt_clear_o <= st_exec && dec.wdt; // RULE11
      sleep_o <= (st_exec && dec.sleep) || (sleep_o && !wake_i); // RULE10
      if (st_exec) begin
        if (dec.upd_c) begin
          status_o.c <= alu_c; // RULE3 RULE7
        end
        if (dec.upd_dc) begin
          status_o.dc <= alu_dc; // RULE7
        end
        if (dec.upd_z) begin
          status_o.z <= (res == 8'h00); // RULE2 RULE6
        end
        if (dec.sleep || dec.wdt) begin
          status_o.to <= 1'b1; // RULE10 RULE11
          status_o.pwrdn <= dec.wdt;
        end
      end
    end
  end

  // Register port: mirror, control, status
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= CTRL_RESET;
      reg_rdata_o <= MIRROR_RESET;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        ctrl_q <= reg_wdata_i;
      end
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          REG_MIRROR: reg_rdata_o <= 8'(cmp_q); // RULE15
          REG_CTRL: reg_rdata_o <= ctrl_q;
          REG_STATUS: reg_rdata_o <= 8'({sleep_o, status_o});
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_nop_cycle;
    state_q == ST_NOPF ##1 state_q == ST_NOPE ##1 state_q == ST_FETCH;
  endsequence

  a_two_cycle_nop: assert property (st_exec && two_cyc |=> s_nop_cycle) // RULE14
    else $error("branch or skip missing NOP cycle");
  a_one_cycle_op: assert property (st_exec && !two_cyc && !dec.sleep |=> state_q == ST_FETCH) // RULE14
    else $error("single-cycle op took extra cycle");
  a_skip_zero_pc: assert property (st_exec && dec.skip_z && res == 8'h00
    |=> pm_addr_o == $past(pm_addr_o) + PC_TWO) // RULE4
    else $error("count-and-skip did not skip");
  a_skip_flags_kept: assert property (st_exec && (dec.skip_z || dec.skip_clr || dec.skip_set)
    |=> status_o == $past(status_o)) // RULE5
    else $error("skip op changed flags");
  a_logic_zero: assert property (st_exec && !dec.lit && dec.op inside {ALU_IOR, ALU_AND, ALU_XOR}
    |=> status_o.z == ($past(res) == 8'h00) && status_o.c == $past(status_o.c)) // RULE2
    else $error("file logic flag update wrong");
  a_rotate_carry: assert property (st_exec && dec.op == ALU_ROTL
    |=> status_o.c == $past(a_src[7]) && status_o.z == $past(status_o.z)) // RULE3
    else $error("rotate carry wrong");
  a_literal_add: assert property (st_exec && dec.lit && dec.op == ALU_ADD
    |=> w_o == $past(res) && status_o.c == $past(alu_c)) // RULE7
    else $error("literal add result wrong");
  a_file_dest: assert property (st_exec && dec.wr_f
    |=> file_we_o && file_wdata_o == $past(res) ##1 !file_we_o) // RULE16
    else $error("file write-back wrong");
  a_standby_flags: assert property (st_exec && dec.sleep
    |=> status_o.to && !status_o.pwrdn && sleep_o) // RULE10
    else $error("standby flags wrong");
  a_wdt_flags: assert property (st_exec && dec.wdt |=> wdt_clear_o && status_o.pwrdn ##1 !wdt_clear_o) // RULE11
    else $error("watchdog clear wrong");
  a_prescaler_clr: assert property (st_exec |=> prescaler_clear_o == $past(tmr_hit)) // RULE13
    else $error("prescaler clear wrong");
  a_port_operand: assert property (st_exec && !dec.lit && file_addr_o == PORT_ADDR
    |-> a_src == pins_q) // RULE12
    else $error("port operand not from pins");
  a_mirror_read: assert property (reg_rd_i && reg_addr_i == REG_MIRROR
    |=> reg_rdata_o == 8'($past(cmp_q))) // RULE15
    else $error("mirror read wrong");
  a_call_push: assert property (st_exec && dec.call
    |=> pm_addr_o == $past(instr_q[10:0]) && stack_top == $past(pm_addr_o) + PC_ONE) // RULE17
    else $error("call target or push wrong");
  a_return_pc: assert property (st_exec && dec.ret |=> pm_addr_o == $past(stack_top)) // RULE9
    else $error("return address wrong");
  a_return_with_literal_w: assert property (st_exec && dec.ret && dec.lit |=> w_o == $past(instr_q[7:0])) // RULE8
    else $error("return literal not in W");
endmodule
`default_nettype wire

// ===== tb/mcuid_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcuid_mem_model (
  input wire logic clk_sys_i,
  input wire logic [10:0] pm_addr_i,
  output logic [13:0] pm_data_o,
  input wire logic [6:0] file_addr_i,
  output logic [7:0] file_rdata_o,
  input wire logic [7:0] file_wdata_i,
  input wire logic file_we_i
);
  logic [13:0] rom [0:2047];
  logic [7:0] ram [0:127];
  // Program words and file bytes answer at once
  assign pm_data_o = rom[pm_addr_i];
  assign file_rdata_o = ram[file_addr_i];
  // File write lands at the edge that ends the strobe
  always_ff @(posedge clk_sys_i) begin
    if (file_we_i) begin
      ram[file_addr_i] <= file_wdata_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb/mcu_14bit_instruction_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_14bit_instruction_decoder_test;
  import mcuid_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] pmd;
  logic [10:0] pc;
  logic [6:0] fa;
  logic [7:0] frd, fwd, w, rdat;
  logic fwe, pclr, wclr, slp;
  logic cmp1 = 1'b1;
  logic cmp2 = 1'b0;
  logic wake = 1'b0;
  logic psa = 1'b1;
  logic [1:0] radr = 2'h0;
  logic [7:0] rwd = 8'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  mcuid_flags_t st;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int npc = 0;
  int nwd = 0;
  int arr [0:31];
  logic [7:0] d;
  localparam logic [13:0] PROG [0:18] = '{14'h300F, 14'h00A0, 14'h3001, 14'h07A0,
    14'h3EFF, 14'h0DA0, 14'h0BA0, 14'h3C05, 14'h0520, 14'h1420, 14'h1820, 14'h1C20,
    14'h3077, 14'h0064, 14'h0805, 14'h0081, 14'h2012, 14'h2811, 14'h3455};

  mcuid_core DUT (.clk_sys_i(clk), .arst_n_i(rst_n), .pm_data_i(pmd), .pm_addr_o(pc),
    .file_addr_o(fa), .file_rdata_i(frd), .file_wdata_o(fwd), .file_we_o(fwe),
    .port_pins_i(8'hA5), .cmp1_output_i(cmp1), .cmp2_output_i(cmp2),
    .prescaler_on_timer_i(psa), .prescaler_clear_o(pclr), .wdt_clear_o(wclr),
    .wake_i(wake), .sleep_o(slp), .w_o(w), .status_o(st), .reg_addr_i(radr),
    .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdat));
  mcuid_mem_model mem (.clk_sys_i(clk), .pm_addr_i(pc), .pm_data_o(pmd), .file_addr_i(fa),
    .file_rdata_o(frd), .file_wdata_i(fwd), .file_we_i(fwe));

  always #2.5 clk = ~clk;
  // Cycle count and side-effect pulse tallies
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pclr === 1'b1) npc <= npc + 1;
    if (wclr === 1'b1) nwd <= nwd + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Poll the program counter until it shows a, bounded
  task automatic run_to(input int a);
    for (int i = 0; i < 300; i++) begin
      if (pc === 11'(a)) begin
        arr[a] = cyc;
        return;
      end
      @(posedge clk);
      #1;
    end
    miscompares++;
    finish_test();
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge clk);
    radr <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    q = rdat;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    radr <= a;
    rwd <= v;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask

  initial begin
    for (int i = 0; i < 2048; i++) mem.rom[i] = (i < 19) ? PROG[i] : 14'h0000;
    for (int i = 0; i < 128; i++) mem.ram[i] = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    check(16'(st), 16'h0018);
    rst_n <= 1'b1;
    run_to(5);
    check(w, 16'h0000);
    check(16'(st), 16'h001F);
    check(mem.ram[32], 16'h0010);
    run_to(6);
    check(16'(st), 16'h001E);
    run_to(7);
    check(16'(st), 16'h001E);
    run_to(8);
    check(w, 16'h0005);
    check(16'(st), 16'h001B);
    check(mem.ram[32], 16'h0020);
    run_to(9);
    check(16'(st), 16'h001F);
    check(w, 16'h0000);
    run_to(10);
    run_to(11);
    check(16'(arr[11] - arr[10]), 16'd2);
    run_to(13);
    run_to(14);
    check(w, 16'h0000);
    check(16'(arr[14] - arr[13]), 16'd4);
    run_to(15);
    check(w, 16'h00A5);
    run_to(17);
    check(w, 16'h0055);
    check(16'(st), 16'h001B);
    check(mem.ram[1], 16'h00A5);
    check(mem.ram[32], 16'h0021);
    check(16'(npc), 16'd1);
    check(16'(nwd), 16'd1);
    // Mirror register, read-only, unmapped offset
    reg_rd(2'h0, d);
    check(d, 16'h0001);
    cmp1 <= 1'b0;
    cmp2 <= 1'b1;
    reg_wr(2'h0, 8'hFF);
    repeat (6) @(posedge clk);
    reg_rd(2'h0, d);
    check(d, 16'h0002);
    reg_rd(2'h1, d);
    check(d, 16'h0001);
    reg_rd(2'h3, d);
    check(d, 16'h0000);
    // Second reset, standby program
    @(posedge clk);
    rst_n <= 1'b0;
    psa <= 1'b0;
    mem.rom[0] = 14'h0081;
    mem.rom[1] = 14'h0063;
    mem.rom[2] = 14'h2802;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    run_to(2);
    check(16'(npc), 16'd1);
    check(slp, 16'h0001);
    check(16'(st), 16'h0010);
    wake <= 1'b1;
    for (int i = 0; i < 20 && slp !== 1'b0; i++) @(posedge clk);
    #1;
    check(slp, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
